/* design/mhd_pkg.sv */
// constants shared by the modem host data interface controller
`default_nettype none
package mhd_pkg;
  // ----------------------------------------------------------------
  // device register addresses on the serial register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_TXW0 = 8'hB5;
  localparam logic [7:0] DEV_TXW1 = 8'hB6;
  localparam logic [7:0] DEV_TXW2 = 8'hB7;
  localparam logic [7:0] DEV_TXW3 = 8'hCA;
  localparam logic [7:0] DEV_TXW4 = 8'hCB;
  localparam logic [7:0] DEV_RXW0 = 8'hB8;
  localparam logic [7:0] DEV_RXW1 = 8'hB9;
  localparam logic [7:0] DEV_RXW2 = 8'hBA;
  localparam logic [7:0] DEV_RXW3 = 8'hBB;
  localparam logic [7:0] DEV_RXW4 = 8'hC5;
  localparam logic [7:0] DEV_MODE = 8'hC1;
  localparam logic [7:0] DEV_STATUS = 8'hC6;
  localparam logic [7:0] DEV_PROG = 8'hC8;
  localparam logic [7:0] DEV_MASK = 8'hCE;
  // ----------------------------------------------------------------
  // field layouts and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;
  localparam logic [3:0] SUB_RAW = 4'h2;
  localparam int SUB_LSB = 4;
  localparam int CNT_LSB = 6;
  localparam logic [1:0] BLOCK_ID = 2'h1;
  localparam int WORDS = 5;
  localparam logic [4:0] BITS_CMD = 5'h08;
  localparam logic [4:0] BITS_WORD = 5'h18;
  // ----------------------------------------------------------------
  // own APB map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_WDATA = 8'h04;
  localparam logic [7:0] A_RDATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_TXB = 8'h10;
  localparam logic [7:0] A_RXB = 8'h24;
  localparam int ST_REFUSED = 1;
  localparam int ST_RXLOST = 12;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int SETTLE_NS = 250000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF = 4;
  typedef enum logic [2:0] {
    OP_WR, OP_RD, OP_CMD, OP_TXBLK, OP_RXBLK
  } mhd_op_e;
endpackage
`default_nettype wire

/* design/mhd_host_ctrl.sv */
// host controller driving the modem over its serial register bus
//
// Behaviour
// - programming register written only in idle
// - sub-mode written together with mode bits
// - load transmit block before raw transmit
// - supply next 72 bits on payload ready
// - read receive block before it is overwritten
// - soft decisions need four times service rate
// - five 16-bit words, info byte then payload
// - block identifier written as 01
// - transaction counter incremented modulo four
// - counter word written last in block
//
// Decided for this implementation: the APB register port.
`default_nettype none
module mhd_host_ctrl
  import mhd_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ser_sel_n,
  output logic ser_clk,
  output logic ser_cmd,
  input wire logic ser_reply,
  input wire logic irq_out_n,
  input wire logic mode_indicator_pin_one,
  input wire logic mode_indicator_pin_two
);
  typedef enum {S_IDLE, S_LOAD, S_LOW, S_HIGH, S_END, S_SETTLE} mhd_st_e;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // order of words in a block: transmit sends the counter word last
  function automatic logic [2:0] blk_word(input mhd_op_e op,
                                          input logic [2:0] step);
    if (op == OP_TXBLK) blk_word = (step == 3'h4) ? 3'h0 : step + 3'h1;
    else blk_word = step;
  endfunction

  function automatic logic [7:0] word_addr(input mhd_op_e op,
                                           input logic [2:0] w);
    logic [7:0] a;
    a = DEV_RXW0;
    case (w)
      3'h0: a = (op == OP_TXBLK) ? DEV_TXW0 : DEV_RXW0;
      3'h1: a = (op == OP_TXBLK) ? DEV_TXW1 : DEV_RXW1;
      3'h2: a = (op == OP_TXBLK) ? DEV_TXW2 : DEV_RXW2;
      3'h3: a = (op == OP_TXBLK) ? DEV_TXW3 : DEV_RXW3;
      default: a = (op == OP_TXBLK) ? DEV_TXW4 : DEV_RXW4;
    endcase
    word_addr = a;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_ff, sync2_ff;
  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
    end else begin
      sync1_ff <= {mode_indicator_pin_two, mode_indicator_pin_one,
                   irq_out_n, ser_reply};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // register file and command acceptance
  // ----------------------------------------------------------------
  logic [15:0] tx_buf_ff [WORDS];
  logic [15:0] nxt_tx_buf [WORDS];
  logic [15:0] wdata_ff, nxt_wdata;
  logic [7:0] caddr_ff, nxt_caddr;
  mhd_op_e cop_ff, nxt_cop;
  logic [1:0] mode_ff, nxt_mode;
  logic tx_loaded_ff, nxt_tx_loaded;
  logic refused_ff, nxt_refused;
  logic rxlost_ff, nxt_rxlost;
  logic [31:0] prdata_ff, nxt_prdata;
  logic start, busy_ff, blk_done;
  logic [1:0] tx_cnt_ff;
  logic [15:0] rdata_ff;
  logic [15:0] rx_buf_ff [WORDS];
  logic rx_seq_bad;
  logic [31:0] status;
  logic wr_acc, rd_set;
  logic [2:0] ti, ri;

  assign wr_acc = psel & penable & pwrite;
  assign rd_set = psel & ~penable & ~pwrite;
  assign ti = 3'((paddr - A_TXB) >> 2);
  assign ri = 3'((paddr - A_RXB) >> 2);
  assign status = {19'h0, rxlost_ff, 2'(rx_buf_ff[0][CNT_LSB +: 2]),
                   mode_ff, tx_cnt_ff, tx_loaded_ff, sync2_ff[3],
                   sync2_ff[2], ~sync2_ff[1], refused_ff, busy_ff};

  // decode, refusal of unsafe orders and shadow state
  always_comb begin
    nxt_tx_buf = tx_buf_ff;
    nxt_wdata = wdata_ff;
    nxt_caddr = caddr_ff;
    nxt_cop = cop_ff;
    nxt_mode = mode_ff;
    nxt_tx_loaded = tx_loaded_ff;
    nxt_refused = refused_ff;
    nxt_rxlost = rxlost_ff;
    nxt_prdata = prdata_ff;
    start = 1'b0;
    if (wr_acc) begin
      if (paddr == A_WDATA) nxt_wdata = pwdata[15:0];
      if (paddr == A_STAT) begin
        if (pwdata[ST_REFUSED]) nxt_refused = 1'b0;
        if (pwdata[ST_RXLOST]) nxt_rxlost = 1'b0;
      end
      if (paddr >= A_TXB && paddr < A_RXB && paddr[1:0] == 2'h0)
        nxt_tx_buf[ti] = pwdata[15:0];
      if (paddr == A_CMD) begin
        if (busy_ff || pwdata[2:0] > 3'(OP_RXBLK)) begin
          nxt_refused = 1'b1;
        end else if (mhd_op_e'(pwdata[2:0]) == OP_WR &&
                     pwdata[15:8] == DEV_PROG && mode_ff != MODE_IDLE) begin
          nxt_refused = 1'b1;
        end else if (mhd_op_e'(pwdata[2:0]) == OP_WR &&
                     pwdata[15:8] == DEV_MODE &&
                     wdata_ff[1:0] == MODE_TX &&
                     wdata_ff[SUB_LSB +: 4] == SUB_RAW && !tx_loaded_ff) begin
          nxt_refused = 1'b1;
        end else begin
          start = 1'b1;
          nxt_cop = mhd_op_e'(pwdata[2:0]);
          nxt_caddr = pwdata[15:8];
          // mode and sub-mode leave in one write of the whole word
          if (nxt_cop == OP_WR && pwdata[15:8] == DEV_MODE) begin
            nxt_mode = wdata_ff[1:0];
            if (wdata_ff[1:0] == MODE_TX) nxt_tx_loaded = 1'b0;
          end
        end
      end
    end
    if (blk_done && cop_ff == OP_TXBLK) nxt_tx_loaded = 1'b1;
    if (rx_seq_bad) nxt_rxlost = 1'b1; // set wins over clear
    if (rd_set) begin
      nxt_prdata = 32'h0;
      if (paddr == A_WDATA) nxt_prdata = {16'h0, wdata_ff};
      if (paddr == A_RDATA) nxt_prdata = {16'h0, rdata_ff};
      if (paddr == A_STAT) nxt_prdata = status;
      if (paddr >= A_TXB && paddr < A_RXB && paddr[1:0] == 2'h0)
        nxt_prdata = {16'h0, tx_buf_ff[ti]};
      if (paddr >= A_RXB && ri < 3'(WORDS) && paddr[1:0] == 2'h0)
        nxt_prdata = {16'h0, rx_buf_ff[ri]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) tx_buf_ff[i] <= 16'h0000;
      wdata_ff <= 16'h0000;
      caddr_ff <= 8'h00;
      cop_ff <= OP_WR;
      mode_ff <= MODE_IDLE; // device wakes idle
      tx_loaded_ff <= 1'b0;
      refused_ff <= 1'b0;
      rxlost_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      tx_buf_ff <= nxt_tx_buf;
      wdata_ff <= nxt_wdata;
      caddr_ff <= nxt_caddr;
      cop_ff <= nxt_cop;
      mode_ff <= nxt_mode;
      tx_loaded_ff <= nxt_tx_loaded;
      refused_ff <= nxt_refused;
      rxlost_ff <= nxt_rxlost;
      prdata_ff <= nxt_prdata;
    end
  end

  // zero wait state slave, read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  mhd_st_e st_ff, nxt_st;
  logic [23:0] sh_ff, nxt_sh;
  logic [15:0] rsh_ff, nxt_rsh;
  logic [4:0] nbits_ff, nxt_nbits, bit_ff, nxt_bit;
  logic [2:0] step_ff, nxt_step;
  logic [13:0] div_ff, nxt_div;
  logic [31:0] wait_ff, nxt_wait;
  logic [1:0] nxt_tx_cnt;
  logic [15:0] nxt_rdata;
  logic [15:0] nxt_rx_buf [WORDS];
  logic nxt_busy, sel_n_ff, nxt_sel_n, clk_ff, nxt_clk;
  logic [2:0] w;
  logic [15:0] word;
  logic blk_op, half_done;

  assign blk_op = (cop_ff == OP_TXBLK) || (cop_ff == OP_RXBLK);
  assign w = blk_word(cop_ff, step_ff);
  assign half_done = div_ff == 14'(SCLK_HALF - 1);
  // info byte: counter, fixed block id, byte count from software
  assign word = (w == 3'h0) ? {tx_buf_ff[0][15:8], tx_cnt_ff + 2'h1,
                               BLOCK_ID, tx_buf_ff[0][3:0]}
                            : tx_buf_ff[w];

  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_rsh = rsh_ff;
    nxt_nbits = nbits_ff;
    nxt_bit = bit_ff;
    nxt_step = step_ff;
    nxt_div = div_ff;
    nxt_wait = wait_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_rdata = rdata_ff;
    nxt_rx_buf = rx_buf_ff;
    nxt_busy = busy_ff;
    nxt_sel_n = sel_n_ff;
    nxt_clk = clk_ff;
    blk_done = 1'b0;
    rx_seq_bad = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (start) begin
          nxt_busy = 1'b1;
          nxt_step = 3'h0;
          nxt_st = S_LOAD;
        end
      end
      S_LOAD: begin
        nxt_nbits = (cop_ff == OP_CMD) ? BITS_CMD : BITS_WORD;
        if (blk_op) nxt_sh = {word_addr(cop_ff, w),
                              (cop_ff == OP_TXBLK) ? word : 16'h0000};
        else nxt_sh = {caddr_ff, wdata_ff};
        nxt_bit = 5'h00;
        nxt_div = 14'h0;
        nxt_sel_n = 1'b0;
        nxt_st = S_LOW;
      end
      S_LOW: begin
        nxt_div = div_ff + 14'h1;
        if (half_done) begin
          nxt_div = 14'h0;
          nxt_clk = 1'b1; // device takes the bit on this rise
          nxt_st = S_HIGH;
        end
      end
      S_HIGH: begin
        nxt_div = div_ff + 14'h1;
        if (half_done) begin
          nxt_div = 14'h0;
          nxt_clk = 1'b0;
          nxt_rsh = {rsh_ff[14:0], sync2_ff[0]};
          nxt_sh = {sh_ff[22:0], 1'b0};
          nxt_bit = bit_ff + 5'h01;
          nxt_st = (bit_ff == nbits_ff - 5'h01) ? S_END : S_LOW;
        end
      end
      S_END: begin
        nxt_sel_n = 1'b1;
        nxt_div = div_ff + 14'h1;
        if (half_done) begin
          nxt_div = 14'h0;
          if (cop_ff == OP_RD) nxt_rdata = rsh_ff;
          if (cop_ff == OP_RXBLK) nxt_rx_buf[w] = rsh_ff;
          // counter word comes first; compare before it is overwritten
          if (cop_ff == OP_RXBLK && step_ff == 3'h0 &&
              rsh_ff[CNT_LSB +: 2] != 2'(rx_buf_ff[0][CNT_LSB +: 2] + 2'h1))
            rx_seq_bad = 1'b1;
          if (blk_op && step_ff != 3'(WORDS - 1)) begin
            nxt_step = step_ff + 3'h1;
            nxt_st = S_LOAD;
          end else begin
            blk_done = blk_op;
            if (cop_ff == OP_TXBLK) nxt_tx_cnt = tx_cnt_ff + 2'h1;
            nxt_wait = 32'h0;
            // give the device time to act on a new mode
            nxt_st = (cop_ff == OP_WR && caddr_ff == DEV_MODE) ?
                     S_SETTLE : S_IDLE;
            nxt_busy = (nxt_st == S_SETTLE);
          end
        end
      end
      S_SETTLE: begin
        nxt_wait = wait_ff + 32'h1;
        if (wait_ff == 32'(SETTLE - 1)) begin
          nxt_busy = 1'b0;
          nxt_st = S_IDLE;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= S_IDLE;
      sh_ff <= 24'h000000;
      rsh_ff <= 16'h0000;
      nbits_ff <= 5'h00;
      bit_ff <= 5'h00;
      step_ff <= 3'h0;
      div_ff <= 14'h0;
      wait_ff <= 32'h0;
      tx_cnt_ff <= 2'h0;
      rdata_ff <= 16'h0000;
      for (int i = 0; i < WORDS; i++) rx_buf_ff[i] <= 16'h0000;
      busy_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      clk_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      rsh_ff <= nxt_rsh;
      nbits_ff <= nxt_nbits;
      bit_ff <= nxt_bit;
      step_ff <= nxt_step;
      div_ff <= nxt_div;
      wait_ff <= nxt_wait;
      tx_cnt_ff <= nxt_tx_cnt;
      rdata_ff <= nxt_rdata;
      rx_buf_ff <= nxt_rx_buf;
      busy_ff <= nxt_busy;
      sel_n_ff <= nxt_sel_n;
      clk_ff <= nxt_clk;
    end
  end

  // msb first, data set while the serial clock is low
  assign ser_sel_n = sel_n_ff;
  assign ser_clk = clk_ff;
  assign ser_cmd = sh_ff[23];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_mode_done;
    st_ff == S_END && half_done && cop_ff == OP_WR && caddr_ff == DEV_MODE;
  endsequence

  chk_prog_idle: assert property (
    start && nxt_cop == OP_WR && nxt_caddr == DEV_PROG |->
    mode_ff == MODE_IDLE) else $error("programming write outside idle");
  chk_raw_loaded: assert property (
    start && nxt_cop == OP_WR && nxt_caddr == DEV_MODE &&
    wdata_ff[1:0] == MODE_TX && wdata_ff[SUB_LSB +: 4] == SUB_RAW |->
    tx_loaded_ff) else $error("raw transmit without loaded block");
  chk_mode_whole: assert property (
    start && nxt_cop == OP_WR && nxt_caddr == DEV_MODE |=>
    ##1 nbits_ff == BITS_WORD && sh_ff[15:0] == wdata_ff)
    else $error("mode written without sub-mode");
  chk_info_byte: assert property (
    st_ff == S_LOAD && cop_ff == OP_TXBLK && w == 3'h0 |=>
    sh_ff[5:4] == BLOCK_ID && sh_ff[23:16] == DEV_TXW0)
    else $error("block id not 01");
  chk_cnt_last: assert property (
    st_ff == S_LOAD && cop_ff == OP_TXBLK && w == 3'h0 |->
    step_ff == 3'(WORDS - 1)) else $error("counter word not last");
  chk_cnt_step: assert property (
    blk_done && cop_ff == OP_TXBLK |=> tx_cnt_ff == $past(tx_cnt_ff) + 2'h1)
    else $error("transaction counter not stepped by one");
  chk_settle_hold: assert property (
    s_mode_done |=> busy_ff [*8]) else $error("settle wait cut short");
  chk_sel_gap: assert property (
    $rose(ser_sel_n) |-> ser_sel_n [*3])
    else $error("select gap too short");
  chk_rx_words: assert property (
    blk_done && cop_ff == OP_RXBLK |-> step_ff == 3'(WORDS - 1))
    else $error("receive block not fully read");
endmodule
`default_nettype wire

/* test/mhd_dev_model.sv */
// behavioural modem device on the serial register bus
`default_nettype none
module mhd_dev_model
  import mhd_pkg::*;
(
  input wire logic ser_sel_n,
  input wire logic ser_clk,
  input wire logic ser_cmd,
  input wire logic rx_push,
  output logic ser_reply,
  output logic irq_out_n,
  output logic mode_indicator_pin_one,
  output logic mode_indicator_pin_two
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int F_RDY = 1; // flag positions are a free choice here
  localparam int F_ERR = 2;
  logic [15:0] stat = 16'h0001; // idle, so programming is open
  logic [15:0] mask = 16'h0000;
  logic [15:0] mode = 16'h0000; // comes up idle
  logic [15:0] prog = 16'h0000;
  logic [15:0] tx [5] = '{default: 16'h0000};
  logic [15:0] rx [5] = '{default: 16'h0000};
  logic [23:0] sh = 24'h000000;
  logic [15:0] rd = 16'h0000;
  logic [7:0] last_a = 8'h00;
  logic [1:0] rxc = 2'h0;
  logic q = 1'b0;
  int n = 0;
  // summary bit under the master mask pulls the pin low
  assign irq_out_n = ~(stat[15] & mask[15]);
  // pins mirror the mode field, reserved code leaves both high
  assign mode_indicator_pin_one = mode[1:0] != MODE_RX;
  assign mode_indicator_pin_two = mode[1:0] != MODE_TX;
  // a released line shows the inverse, never a stale bit
  assign ser_reply = ser_sel_n ? ~q : q;
  function automatic logic [15:0] rd_of(input logic [7:0] a);
    case (a)
      DEV_STATUS: return stat;
      DEV_RXW0: return rx[0];
      DEV_RXW1: return rx[1];
      DEV_RXW2: return rx[2];
      DEV_RXW3: return rx[3];
      DEV_RXW4: return rx[4];
      default: return 16'hFFFF;
    endcase
  endfunction
  // each flag has its own mask bit into the summary
  task automatic raise(input int f);
    if (!stat[f] && mask[f]) stat[15] = 1'b1;
    stat[f] = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    case (a)
      DEV_MASK: begin
        if (|(d & ~mask & stat & 16'h7FFE)) stat[15] = 1'b1;
        mask = d;
      end
      DEV_MODE: mode = d; // mode and sub-mode in one word
      DEV_PROG: if (mode[1:0] == MODE_IDLE) prog = d;
      DEV_TXW1: tx[1] = d;
      DEV_TXW2: tx[2] = d;
      DEV_TXW3: tx[3] = d;
      DEV_TXW4: tx[4] = d;
      DEV_TXW0: if (d[7:6] != tx[0][7:6]) begin // new block
        if (d[7:6] != tx[0][7:6] + 2'h1) raise(F_ERR);
        tx[0] = d;
        raise(F_RDY); // block consumed at once
      end
      default: ;
    endcase
  endtask
  // shift in on the rising serial clock, reply during data bits
  always @(posedge ser_clk) if (!ser_sel_n) begin
    sh = {sh[22:0], ser_cmd};
    n = n + 1;
    if (n == 8) begin
      last_a = sh[7:0];
      rd = rd_of(sh[7:0]);
      if (sh[7:0] == DEV_STATUS) stat = stat & 16'h0001;
    end
    if (n > 8) q = rd[24 - n];
  end
  // a whole word takes effect when select rises; 01 is a reset
  always @(posedge ser_sel_n) begin
    if (n == 24) wr(sh[23:16], sh[15:0]);
    if (n == 8 && sh[7:0] == 8'h01) mode = 16'h0000;
    n = 0;
  end
  // received block lands in the receive words
  always @(posedge rx_push) if (mode[1:0] == MODE_RX) begin
    rxc = rxc + 2'h1;
    rx[0] = {8'hA5, rxc, 6'h19};
    for (int k = 1; k < WORDS; k++) rx[k] = 16'(16'h1111 * k);
    raise(F_RDY);
  end
endmodule
`default_nettype wire

/* test/tb_mhd_host_ctrl.sv */
// self-checking bench for the modem host controller
`default_nettype none
module tb_mhd_host_ctrl
  import mhd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rx_push = 1'b0;
  logic [31:0] prdata, q, e;
  logic pready, pslverr, sel_n, sclk, scmd, srep, irq_n, p1, p2;
  int num_errors = 0;
  int checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  // settle wait shortened so mode writes stay cheap
  mhd_host_ctrl #(.SETTLE(20)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_sel_n(sel_n), .ser_clk(sclk), .ser_cmd(scmd), .ser_reply(srep),
    .irq_out_n(irq_n), .mode_indicator_pin_one(p1),
    .mode_indicator_pin_two(p2));
  mhd_dev_model dev (.ser_sel_n(sel_n), .ser_clk(sclk), .ser_cmd(scmd),
    .rx_push(rx_push), .ser_reply(srep), .irq_out_n(irq_n),
    .mode_indicator_pin_one(p1), .mode_indicator_pin_two(p2));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input string s);
    num_errors++;
    $display("FAIL %s expected answer seen timeout", s);
    wrap_up;
  endtask
  task automatic chk(input string s, input logic [31:0] x, y);
    checks++;
    if (y !== x) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", s, x, y);
    end
  endtask
  // setup then access, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) hang("pready");
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic st;
    apb(1'b0, A_STAT, 32'h0);
  endtask
  // device operation, then poll busy under a bound
  task automatic op(input logic [2:0] c, input logic [7:0] a,
                    input logic [15:0] d);
    int k;
    apb(1'b1, A_WDATA, {16'h0000, d});
    apb(1'b1, A_CMD, {16'h0000, a, 5'h00, c});
    k = 0;
    do begin
      st;
      k++;
    end while (q[0] !== 1'b0 && k < 2000);
    if (q[0] !== 1'b0) hang("busy");
  endtask
  task automatic pulse;
    rx_push <= 1'b1;
    @(posedge clk);
    rx_push <= 1'b0;
    @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    st;
    chk("status", 32'h18, q);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("pslverr", 32'h0, {31'h0, pslverr});
    apb(1'b1, A_CMD, 32'h5);
    st;
    chk("bad op", 32'h1, {31'h0, q[ST_REFUSED]});
    apb(1'b1, A_STAT, 32'h2);
    op(OP_RD, DEV_STATUS, 16'h0);
    apb(1'b0, A_RDATA, 32'h0);
    chk("dev status", 32'h1, q);
    $display("test reset done");
  endtask
  task automatic t_modes;
    logic [3:0] s [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
    for (int m = 0; m < 4; m++) begin
      op(OP_WR, DEV_MODE, {14'h0, 2'(m)});
      st;
      chk("pins", {30'h0, m != 2, m != 1}, {30'h0, q[4:3]});
    end
    for (int i = 0; i < 6; i++) begin
      e = {24'h0, s[i], 2'h0, MODE_RX};
      op(OP_WR, DEV_MODE, e[15:0]);
      chk("sub-mode", e, {16'h0, dev.mode});
    end
    $display("test modes done");
  endtask
  task automatic t_prog;
    op(OP_WR, DEV_PROG, 16'h1234);
    st;
    chk("prog refused", 32'h1, {31'h0, q[ST_REFUSED]});
    chk("prog kept", 32'h0, {16'h0, dev.prog});
    apb(1'b1, A_STAT, 32'h2);
    op(OP_CMD, 8'h01, 16'h0);
    chk("cmd reset", 32'h0, {16'h0, dev.mode});
    op(OP_WR, DEV_MODE, 16'h0);
    op(OP_WR, DEV_PROG, 16'h1234);
    chk("prog", 32'h1234, {16'h0, dev.prog});
    $display("test prog done");
  endtask
  task automatic t_tx;
    op(OP_WR, DEV_MODE, {8'h0, SUB_RAW, 2'h0, MODE_TX});
    st;
    chk("tx refused", 32'h1, {31'h0, q[ST_REFUSED]});
    chk("still idle", 32'h0, {16'h0, dev.mode});
    apb(1'b1, A_STAT, 32'h2);
    for (int b = 1; b < 3; b++) begin
      for (int k = 0; k < WORDS; k++)
        apb(1'b1, A_TXB + 8'(4 * k), {16'h0, 8'(8'h5A + k + b), 8'h09});
      op(OP_TXBLK, 8'h00, 16'h0);
      chk("last addr", {24'h0, DEV_TXW0}, {24'h0, dev.last_a});
      e = {16'h0, 8'(8'h5D + b), 8'h09};
      chk("word3", e, {16'h0, dev.tx[3]});
      e = {16'h0, 8'(8'h5A + b), 2'(b), BLOCK_ID, 4'h9};
      chk("info", e, {16'h0, dev.tx[0]});
      if (b == 1) op(OP_WR, DEV_MODE, {8'h0, SUB_RAW, 2'h0, MODE_TX});
    end
    chk("tx mode", 32'h22, {16'h0, dev.mode});
    chk("no seq error", 32'h0, {31'h0, dev.stat[2]});
    $display("test tx done");
  endtask
  task automatic t_irq;
    op(OP_WR, DEV_MASK, 16'h8002);
    st;
    chk("irq set", 32'h1, {31'h0, q[2]});
    op(OP_RD, DEV_STATUS, 16'h0);
    apb(1'b0, A_RDATA, 32'h0);
    chk("dev status", 32'h8003, q);
    st;
    chk("irq clear", 32'h0, {31'h0, q[2]});
    op(OP_TXBLK, 8'h00, 16'h0);
    st;
    chk("irq again", 32'h1, {31'h0, q[2]});
    op(OP_RD, DEV_STATUS, 16'h0);
    $display("test irq done");
  endtask
  task automatic t_rx;
    op(OP_WR, DEV_MODE, {8'h0, SUB_RAW, 2'h0, MODE_RX});
    pulse;
    op(OP_RXBLK, 8'h00, 16'h0);
    for (int k = 0; k < WORDS; k++) begin
      apb(1'b0, A_RXB + 8'(4 * k), 32'h0);
      e = (k == 0) ? 32'hA559 : 32'(16'(16'h1111 * k));
      chk("rx word", e, q);
    end
    st;
    chk("rx count", 32'h1, {30'h0, q[11:10]});
    chk("rx in order", 32'h0, {31'h0, q[ST_RXLOST]});
    pulse;
    pulse;
    op(OP_RXBLK, 8'h00, 16'h0);
    st;
    chk("rx count", 32'h3, {30'h0, q[11:10]});
    chk("rx lost", 32'h1, {31'h0, q[ST_RXLOST]});
    op(OP_WR, DEV_MODE, 16'h0);
    $display("test rx done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_modes;
    t_prog;
    t_tx;
    t_irq;
    t_rx;
    wrap_up;
  end
endmodule
`default_nettype wire
